// file: exv_top.sv
// exv_top: event classification, state save, vector redirect and return
// Assumes the pipeline squashes its execute stage while REDIRECT is valid
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
module exv_top (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire exv_pkg::exv_exec_t EXEC,
  input wire logic BOUNDARY,
  input wire logic [31:0] NEXT_PC,
  input wire logic BREAK_PIN,
  input wire logic IRQ_REQ,
  input wire logic [2:0] IRQ_LEVEL,
  input wire logic [4:0] IRQ_SRC,
  output logic IRQ_ACK,
  output exv_pkg::exv_redir_t REDIRECT,
  output exv_pkg::exv_psw_t PSW_OUT,
  output logic [31:0] SAVED_PC,
  output logic MEM_REQ,
  output logic [31:0] MEM_ADDR,
  input wire logic [15:0] MEM_RDATA,
  input wire logic MEM_ACK,
  output logic EV_IRQ
);
  import exv_pkg::*;

  // ==========================================================
  // Declarations
  logic brk_s1_r, brk_s2_r, brk_prev_r, brk_pend_r;
  exv_psw_t psw_r, saved_status_field_r;
  logic [31:0] saved_pc_r;
  exv_redir_t redir_r;
  exv_cause_t cause, last_cause_r;
  logic [31:0] vec, spc;
  logic sm_clr, take, misal, ext_ok, sbi_ok, live;
  logic [ST_W-1:0] st_r, mask_r, st_nxt, mask_nxt, st_set, st_clr;
  logic pready_r, pslverr_r, irq_ack_r, ev_irq_r;
  logic [31:0] prdata_r;
  logic setup, acc_wr;
  exv_fst_t fst_r;
  logic mem_req_r;
  logic [31:0] mem_addr_r, handler_r;
  logic [15:0] hlo_r;
  logic src_ok;

  // ==========================================================
  // Break pin synchroniser and edge latch
  always_ff @(posedge MCLK) begin
    if (RST) begin
      brk_s1_r <= 1'b0;
      brk_s2_r <= 1'b0;
      brk_prev_r <= 1'b0;
    end else if (CE) begin
      brk_s1_r <= BREAK_PIN;
      brk_s2_r <= brk_s1_r;
      brk_prev_r <= brk_s2_r;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      brk_pend_r <= 1'b0;
    end else if (CE) begin
      if (brk_s2_r && !brk_prev_r) begin
        brk_pend_r <= 1'b1; // [RL8]
      end else if (cause == CS_BREAK) begin
        brk_pend_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Event classification and priority
  assign live = EXEC.valid && !redir_r.valid;
  assign misal = live && EXEC.ls &&
    ((EXEC.size == SZ_HALF && EXEC.alo[0]) ||
     (EXEC.size == SZ_WORD && EXEC.alo != 2'h0)); // [RL6]
  assign ext_ok = IRQ_REQ && IRQ_LEVEL != LVL_OFF && psw_r.ie &&
    BOUNDARY && !redir_r.valid; // [RL9] [RL17]
  assign sbi_ok = brk_pend_r && BOUNDARY && !redir_r.valid; // [RL17]

  always_comb begin
    cause = CS_NONE;
    vec = VEC_RESET;
    spc = EXEC.pc;
    sm_clr = 1'b0;
    if (live && EXEC.resv) begin
      cause = CS_RESV; // [RL5]
      vec = VEC_RESV;
      spc = EXEC.pc; // [RL17]
    end else if (misal) begin
      cause = CS_MISAL; // [RL6]
      vec = VEC_MISAL;
      spc = EXEC.pc; // [RL17]
    end else if (sbi_ok) begin
      cause = CS_BREAK; // [RL8]
      vec = VEC_BREAK;
      spc = NEXT_PC; // [RL17]
      sm_clr = 1'b1; // [RL15]
    end else if (ext_ok) begin
      cause = CS_EXT;
      vec = VEC_EXT; // [RL16]
      spc = NEXT_PC; // [RL17]
      sm_clr = 1'b1; // [RL15]
    end else if (live && EXEC.trap) begin
      cause = CS_TRAP;
      vec = VEC_TRAP + {26'h0, EXEC.op, 2'h0}; // [RL10] [RL16]
      spc = EXEC.pc + TRAP_RET;
    end else if (live && EXEC.ret) begin
      cause = CS_RET;
      vec = saved_pc_r & RET_MASK; // [RL13]
    end
  end

  // Return is not an acceptance: nothing is saved
  assign take = cause != CS_NONE && cause != CS_RET;

  // ==========================================================
  // Status word, backups and fetch redirect
  always_ff @(posedge MCLK) begin
    if (RST) begin
      psw_r <= '0; // [RL7]
      saved_status_field_r <= '0;
    end else if (CE) begin
      // Event save wins over a same-cycle register write
      if (take) begin
        saved_status_field_r <= psw_r; // [RL11] [RL15]
        psw_r.sm <= sm_clr ? 1'b0 : psw_r.sm; // [RL15]
        psw_r.ie <= 1'b0; // [RL15]
        psw_r.c <= 1'b0; // [RL15]
      end else if (cause == CS_RET) begin
        psw_r <= saved_status_field_r; // [RL13] [RL14]
      end else if (acc_wr && PADDR == OFS_PSW) begin
        psw_r.c <= PWDATA[PSW_C];
        psw_r.ie <= PWDATA[PSW_IE];
        psw_r.sm <= PWDATA[PSW_SM];
        saved_status_field_r.c <= PWDATA[PSW_BC];
        saved_status_field_r.ie <= PWDATA[PSW_BIE];
        saved_status_field_r.sm <= PWDATA[PSW_BSM];
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      saved_pc_r <= 32'h0000_0000;
    end else if (CE) begin
      if (take) begin
        saved_pc_r <= spc; // [RL11]
      end
    end
  end

  // Reset holds the redirect to the reset slot
  always_ff @(posedge MCLK) begin
    if (RST) begin
      redir_r <= '{valid: 1'b1, pc: VEC_RESET, cause: CS_RESET}; // [RL7]
      last_cause_r <= CS_RESET;
    end else if (CE) begin
      redir_r.valid <= cause != CS_NONE; // [RL1]
      redir_r.pc <= vec; // [RL1] [RL11]
      redir_r.cause <= cause;
      if (cause != CS_NONE) begin
        last_cause_r <= cause;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      irq_ack_r <= 1'b0;
    end else if (CE) begin
      irq_ack_r <= cause == CS_EXT; // [RL9]
    end
  end

  // ==========================================================
  // Handler table fetch, two halfwords per entry
  assign src_ok = int'(IRQ_SRC) < TBL_N;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      fst_r <= FS_IDLE;
      mem_req_r <= 1'b0;
      mem_addr_r <= TBL_FIRST;
      hlo_r <= 16'h0000;
      handler_r <= 32'h0000_0000;
    end else if (CE) begin
      unique case (fst_r)
        FS_IDLE: begin
          if (cause == CS_EXT && src_ok) begin
            mem_addr_r <= TBL[IRQ_SRC]; // [RL2] [RL4]
            mem_req_r <= 1'b1;
            fst_r <= FS_LO;
          end
        end
        FS_LO: begin
          if (MEM_ACK) begin
            hlo_r <= MEM_RDATA; // [RL3]
            mem_addr_r <= mem_addr_r + HALF_STEP; // [RL3]
            fst_r <= FS_HI;
          end
        end
        FS_HI: begin
          if (MEM_ACK) begin
            handler_r <= {MEM_RDATA, hlo_r}; // [RL3]
            mem_req_r <= 1'b0;
            fst_r <= FS_IDLE;
          end
        end
        // Unused state code falls back to idle
        default: begin
          mem_req_r <= 1'b0;
          fst_r <= FS_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Sticky event status and mask
  always_comb begin
    st_set = '0;
    st_set[ST_RESV] = cause == CS_RESV;
    st_set[ST_MISAL] = cause == CS_MISAL;
    st_set[ST_BREAK] = cause == CS_BREAK;
    st_set[ST_EXT] = cause == CS_EXT;
    st_set[ST_TRAP] = cause == CS_TRAP;
    st_set[ST_RET] = cause == CS_RET;
    st_set[ST_HDL] = fst_r == FS_HI && MEM_ACK;
    st_clr = '0;
    mask_nxt = mask_r;
    if (acc_wr && PADDR == OFS_STATUS) begin
      st_clr = PWDATA[ST_W-1:0];
    end
    if (acc_wr && PADDR == OFS_MASK) begin
      mask_nxt = PWDATA[ST_W-1:0];
    end
    // Set wins over a same-cycle write-one clear
    st_nxt = (st_r & ~st_clr) | st_set;
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      st_r <= '0;
      mask_r <= '0;
      ev_irq_r <= 1'b0;
    end else if (CE) begin
      st_r <= st_nxt;
      mask_r <= mask_nxt;
      ev_irq_r <= |(st_nxt & mask_nxt);
    end
  end

  // ==========================================================
  // APB slave, one wait-free access phase
  assign setup = PSEL && !PENABLE;
  assign acc_wr = PSEL && PENABLE && pready_r && PWRITE;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (CE) begin
      pready_r <= setup;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      if (setup) begin
        unique case (PADDR)
          OFS_STATUS: prdata_r <= {25'h0, st_r};
          OFS_MASK: prdata_r <= {25'h0, mask_r};
          OFS_PSW: prdata_r <= {25'h0, saved_status_field_r, 1'b0, psw_r};
          OFS_SAVED: prdata_r <= saved_pc_r;
          OFS_HANDLER: prdata_r <= handler_r;
          OFS_CAUSE: prdata_r <= {29'h0, last_cause_r};
          default: pslverr_r <= 1'b1;
        endcase
      end
    end
  end

  // ==========================================================
  // Outputs
  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign IRQ_ACK = irq_ack_r;
  assign REDIRECT = redir_r;
  assign PSW_OUT = psw_r;
  assign SAVED_PC = saved_pc_r;
  assign MEM_REQ = mem_req_r;
  assign MEM_ADDR = mem_addr_r;
  assign EV_IRQ = ev_irq_r;
endmodule : exv_top

// file: exv_pkg.sv
// exv_pkg: constants and carrier types of the event vectoring unit
// Assumes one MCLK domain, an APB master and an execute stage upstream
// Behaviour
// (RL1) Vector slots hold branch instructions; the unit redirects fetch there
// (RL2) Controller handler table spans its first to last listed entry only
// (RL3) Handler address is two halfwords, low bits at the lower address
// (RL4) One table slot per source group at its listed address
// (RL5) Unimplemented opcode raises a reserved-opcode fault
// (RL6) Misaligned load or store raises a misalignment fault
// (RL7) Reset is always accepted and outranks every other event
// (RL8) Emergency break is accepted; its handler never returns
// (RL9) Peripheral requests arrive as one request with eight levels, one off
// (RL10) Trap operand 0 to 15 selects one of sixteen vector slots
// (RL11) Non-reset acceptance saves counter and status, then branches
// (RL12) Handler software saves and restores everything else itself
// (RL13) Return restores counter and status from their backups
// (RL14) Backups are undefined after return; nothing preserves them
// (RL15) Mode, enable, condition saved; enable and condition cleared
// (RL16) Slots from zero: reset, traps four bytes apart, external slot
// (RL17) Break and external at word-boundary gaps; faults save own address
package exv_pkg;
  localparam logic [31:0] VEC_RESET = 32'h0000_0000;
  localparam logic [31:0] VEC_BREAK = 32'h0000_0010;
  localparam logic [31:0] VEC_RESV = 32'h0000_0020;
  localparam logic [31:0] VEC_MISAL = 32'h0000_0030;
  localparam logic [31:0] VEC_TRAP = 32'h0000_0040;
  localparam logic [31:0] VEC_EXT = 32'h0000_0080;
  localparam logic [31:0] TRAP_RET = 32'h0000_0004;
  localparam logic [31:0] RET_MASK = 32'hFFFF_FFFC;
  localparam logic [31:0] HALF_STEP = 32'h0000_0002;
  localparam logic [31:0] TBL_FIRST = 32'h0000_0094;
  localparam logic [31:0] TBL_LAST = 32'h0000_0112;
  localparam int TBL_N = 23;
  localparam logic [31:0] TBL [TBL_N] = '{
    32'h0000_0094, 32'h0000_0098, 32'h0000_009C, 32'h0000_00A0,
    32'h0000_00A8, 32'h0000_00AC, 32'h0000_00B0, 32'h0000_00B4,
    32'h0000_00B8, 32'h0000_00BC, 32'h0000_00C0, 32'h0000_00C4,
    32'h0000_00C8, 32'h0000_00CC, 32'h0000_00D0, 32'h0000_00D4,
    32'h0000_00D8, 32'h0000_00DC, 32'h0000_00E8, 32'h0000_00EC,
    32'h0000_00F0, 32'h0000_010C, 32'h0000_0110};
  localparam logic [2:0] LVL_OFF = 3'h7;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_MASK = 12'h004;
  localparam logic [11:0] OFS_PSW = 12'h008;
  localparam logic [11:0] OFS_SAVED = 12'h00C;
  localparam logic [11:0] OFS_HANDLER = 12'h010;
  localparam logic [11:0] OFS_CAUSE = 12'h014;
  localparam int ST_W = 7;
  localparam int ST_RESV = 0;
  localparam int ST_MISAL = 1;
  localparam int ST_BREAK = 2;
  localparam int ST_EXT = 3;
  localparam int ST_TRAP = 4;
  localparam int ST_RET = 5;
  localparam int ST_HDL = 6;
  localparam int PSW_C = 0;
  localparam int PSW_IE = 1;
  localparam int PSW_SM = 2;
  localparam int PSW_BC = 4;
  localparam int PSW_BIE = 5;
  localparam int PSW_BSM = 6;
  typedef struct packed {
    logic sm;
    logic ie;
    logic c;
  } exv_psw_t;
  typedef enum logic [2:0] {
    CS_NONE, CS_RESET, CS_BREAK, CS_RESV, CS_MISAL, CS_TRAP, CS_EXT, CS_RET
  } exv_cause_t;
  typedef struct packed {
    logic valid;
    logic [31:0] pc;
    logic resv;
    logic ls;
    logic [1:0] size;
    logic [1:0] alo;
    logic trap;
    logic [3:0] op;
    logic ret;
  } exv_exec_t;
  typedef struct packed {
    logic valid;
    logic [31:0] pc;
    exv_cause_t cause;
  } exv_redir_t;
  typedef enum logic [1:0] {FS_IDLE, FS_LO, FS_HI} exv_fst_t;
endpackage : exv_pkg

// file: exv_chk.sv
// exv_chk: timing and value checks on the event vectoring unit ports
// Assumes a bind to exv_top and one MCLK domain
module exv_chk
  import exv_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CE,
  input wire exv_pkg::exv_exec_t EXEC,
  input wire logic BOUNDARY,
  input wire logic [31:0] NEXT_PC,
  input wire logic IRQ_REQ,
  input wire logic [2:0] IRQ_LEVEL,
  input wire exv_pkg::exv_redir_t REDIRECT,
  input wire exv_pkg::exv_psw_t PSW_OUT,
  input wire logic [31:0] SAVED_PC,
  input wire logic [4:0] IRQ_SRC,
  input wire logic IRQ_ACK,
  input wire logic MEM_REQ,
  input wire logic [31:0] MEM_ADDR
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  logic go;
  logic mis;
  assign go = CE && EXEC.valid && !REDIRECT.valid;
  assign mis = EXEC.ls && ((EXEC.size == SZ_HALF && EXEC.alo[0]) ||
    (EXEC.size == SZ_WORD && EXEC.alo != 2'h0));
  // ==========
  // Redirect of a given cause
  sequence taken(exv_cause_t c);
    REDIRECT.valid && REDIRECT.cause == c;
  endsequence
  rst_vec_a:
    assert property (disable iff (1'h0) RST |=> REDIRECT.valid &&
      REDIRECT.cause == CS_RESET && REDIRECT.pc == VEC_RESET)
    else $error("reset not vectored");
  resv_vec_a:
    assert property (go && EXEC.resv |=> taken(CS_RESV) ##0
      (REDIRECT.pc == VEC_RESV && SAVED_PC == $past(EXEC.pc)))
    else $error("reserved opcode not vectored");
  mis_vec_a:
    assert property (go && !EXEC.resv && mis |=> taken(CS_MISAL) ##0
      (REDIRECT.pc == VEC_MISAL && SAVED_PC == $past(EXEC.pc)))
    else $error("misalignment not vectored");
  trap_vec_a:
    assert property (go && EXEC.trap && !EXEC.resv && !EXEC.ls && !BOUNDARY
      |=> taken(CS_TRAP) ##0 (SAVED_PC == $past(EXEC.pc) + TRAP_RET &&
      REDIRECT.pc == VEC_TRAP + 32'($past(EXEC.op)) * 4))
    else $error("trap slot wrong");
  ext_gate_a:
    assert property (taken(CS_EXT) |-> $past(IRQ_REQ && BOUNDARY &&
      IRQ_LEVEL != LVL_OFF && PSW_OUT.ie))
    else $error("external taken without request");
  gap_save_a:
    assert property (taken(CS_EXT) or taken(CS_BREAK) |->
      SAVED_PC == $past(NEXT_PC) && !PSW_OUT.sm)
    else $error("next address not saved");
  psw_clr_a:
    assert property (REDIRECT.valid && REDIRECT.cause inside {CS_BREAK,
      CS_RESV, CS_MISAL, CS_TRAP, CS_EXT} |-> !PSW_OUT.ie && !PSW_OUT.c &&
      (REDIRECT.cause inside {CS_BREAK, CS_EXT} || PSW_OUT.sm ==
      $past(PSW_OUT.sm)))
    else $error("status bits not updated");
  ret_pc_a:
    assert property (taken(CS_RET) |-> REDIRECT.pc ==
      ($past(SAVED_PC) & RET_MASK))
    else $error("return address wrong");
  redir_one_a:
    assert property (REDIRECT.valid && CE && !RST |=> !REDIRECT.valid)
    else $error("redirect longer than one cycle");
  ack_pulse_a:
    assert property (IRQ_ACK == (REDIRECT.valid && REDIRECT.cause == CS_EXT))
    else $error("acknowledge not paired with external event");
  fetch_go_a:
    assert property (REDIRECT.valid && REDIRECT.cause == CS_EXT &&
      !$past(MEM_REQ) && $past(IRQ_SRC) < TBL_N |->
      MEM_REQ && MEM_ADDR == TBL[$past(IRQ_SRC)])
    else $error("handler table fetch not started");
endmodule : exv_chk

// file: exv_ctl_model.sv
// exv_ctl_model: interrupt controller and handler table memory
// Assumes the MCLK domain of exv_top and its synchronous reset
module exv_ctl_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic fire,
  input wire logic [2:0] lvl,
  input wire logic [4:0] src,
  input wire logic [3:0] dly,
  input wire logic ack_in,
  input wire logic req,
  input wire logic [31:0] addr,
  output logic irq,
  output logic [2:0] level,
  output logic [4:0] sid,
  output logic [15:0] rdata,
  output logic mack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_r;
  // ==========
  // Request held until acknowledged
  always_ff @(posedge clk) begin
    level <= lvl;
    sid <= src;
    if (rst)
      irq <= 1'h0;
    else if (fire)
      irq <= 1'h1;
    else if (ack_in)
      irq <= 1'h0;
  end
  // Halfword per address, idle bus toggles
  always_ff @(posedge clk) begin
    mack <= 1'h0;
    rdata <= ~rdata;
    if (rst) begin
      wait_r <= 4'h0;
      rdata <= 16'h0;
    end else if (req && !mack) begin
      wait_r <= wait_r + 4'h1;
      if (wait_r == dly) begin
        mack <= 1'h1;
        rdata <= addr[15:0] ^ 16'h5A3C;
        wait_r <= 4'h0;
      end
    end
  end
endmodule : exv_ctl_model

// file: testbench.sv
// testbench: random and corner event traffic against exv_top
// Assumes exv_ctl_model as controller and table memory
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import exv_pkg::*;
  logic MCLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, er, fire = 0;
  logic PREADY, PSLVERR, BOUNDARY = 0, BREAK_PIN = 0, IRQ_REQ, IRQ_ACK;
  logic MEM_REQ, MEM_ACK, EV_IRQ;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, NEXT_PC = '0, SAVED_PC, MEM_ADDR, hd, sp;
  logic [2:0] IRQ_LEVEL, lvl = 3'h0;
  logic [4:0] IRQ_SRC, src = 5'h0;
  logic [15:0] MEM_RDATA;
  logic [3:0] dly = 4'h0;
  exv_exec_t EXEC = '0, e;
  exv_redir_t REDIRECT, r;
  exv_psw_t PSW_OUT, ps;
  int seed = 32'h615b8e46, fail_count = 0, n_tests = 0;
  always #10 MCLK = ~MCLK;
  exv_top i_exv_top (.CE(1'h1), .*);
  exv_ctl_model i_exv_ctl_model (.clk(MCLK), .rst(RST), .fire(fire),
    .lvl(lvl), .src(src), .dly(dly), .ack_in(IRQ_ACK), .req(MEM_REQ),
    .addr(MEM_ADDR), .irq(IRQ_REQ), .level(IRQ_LEVEL), .sid(IRQ_SRC),
    .rdata(MEM_RDATA), .mack(MEM_ACK));
  task automatic check(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic wrap_up;
    if (fail_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge MCLK);
    PSEL <= 1'h1;
    PENABLE <= 1'h0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'h1;
    do @(posedge MCLK); while (PREADY !== 1'h1);
    hd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask : apb
  // ==========
  // One instruction or line event, first redirect captured
  task automatic ev(input exv_exec_t x, input logic b, k, f);
    @(posedge MCLK);
    EXEC <= x;
    BOUNDARY <= b;
    BREAK_PIN <= k;
    fire <= f;
    NEXT_PC <= $random(seed) & RET_MASK;
    @(posedge MCLK);
    EXEC <= '0;
    fire <= 1'h0;
    r = '0;
    repeat (30) begin
      @(negedge MCLK);
      if (REDIRECT.valid === 1'h1 && r.valid !== 1'h1) begin
        r = REDIRECT;
        sp = SAVED_PC;
        ps = PSW_OUT;
      end
    end
  endtask : ev
  task automatic do_reset;
    RST <= 1'h1;
    repeat (10) @(posedge MCLK);
    @(negedge MCLK);
    check("rst_vec", {REDIRECT.cause, REDIRECT.pc[28:0]}, 32'h20000000);
    @(posedge MCLK);
    RST <= 1'h0;
  endtask : do_reset
  function automatic logic [15:0] hw(input logic [31:0] a);
    return a[15:0] ^ 16'h5A3C;
  endfunction : hw
  initial begin
    do_reset();
    apb(1'h0, 12'h018, '0);
    check("unmapped", er, 1'h1);
    apb(1'h1, OFS_MASK, 32'h7F);
    apb(1'h1, OFS_PSW, 32'h07);
    e = '0;
    e.valid = 1'h1;
    e.resv = 1'h1;
    e.pc = $random(seed) | 32'h2;
    ev(e, 1'h0, 1'h0, 1'h0);
    check("resv_vec", r.pc, VEC_RESV);
    check("resv_bpc", sp, e.pc);
    check("resv_psw", ps, 3'h4);
    check("irq_out", EV_IRQ, 1'h1);
    apb(1'h0, OFS_PSW, '0);
    check("saved_status_field", hd, 32'h74);
    apb(1'h0, OFS_SAVED, '0);
    check("bpc_push", hd, e.pc);
    apb(1'h0, OFS_CAUSE, '0);
    check("cause", hd, 32'(CS_RESV));
    ev('{valid: 1'h1, ret: 1'h1, default: '0}, 1'h0, 1'h0, 1'h0);
    check("ret_pc", r.pc, e.pc & RET_MASK);
    check("ret_psw", ps, 3'h7);
    for (int i = 0; i < 12; i++) begin
      e = '0;
      e.valid = 1'h1;
      e.ls = 1'h1;
      e.size = 2'(i / 4);
      e.alo = 2'(i);
      e.pc = $random(seed);
      ev(e, 1'h0, 1'h0, 1'h0);
      check("misal", r.valid, (e.size == SZ_HALF && e.alo[0]) ||
        (e.size == SZ_WORD && e.alo != 2'h0));
    end
    for (int i = 0; i < 16; i++) begin
      e = '0;
      e.valid = 1'h1;
      e.trap = 1'h1;
      e.op = 4'(i);
      e.pc = $random(seed) & RET_MASK;
      ev(e, 1'h0, 1'h0, 1'h0);
      check("trap_vec", r.pc, VEC_TRAP + 4 * i);
      check("trap_bpc", sp, e.pc + TRAP_RET);
    end
    apb(1'h1, OFS_PSW, 32'h06);
    lvl = LVL_OFF;
    src = 5'({$random(seed)} % TBL_N);
    dly = 4'({$random(seed)} % 8);
    ev('0, 1'h1, 1'h0, 1'h1);
    check("ext_off", r.valid, 1'h0);
    lvl = 3'({$random(seed)} % 7);
    ev('0, 1'h1, 1'h0, 1'h0);
    check("ext_vec", r.pc, VEC_EXT);
    check("ext_bpc", sp, NEXT_PC);
    apb(1'h0, OFS_HANDLER, '0);
    check("handler", hd, {hw(TBL[src] + 2), hw(TBL[src])});
    ev('0, 1'h1, 1'h1, 1'h0);
    check("brk_vec", r.pc, VEC_BREAK);
    check("brk_bpc", sp, NEXT_PC);
    apb(1'h1, OFS_MASK, '0);
    repeat (2) @(negedge MCLK);
    check("irq_mask", EV_IRQ, 1'h0);
    apb(1'h1, OFS_MASK, 32'h7F);
    apb(1'h1, OFS_STATUS, 32'h7F);
    repeat (2) @(negedge MCLK);
    check("irq_clr", EV_IRQ, 1'h0);
    do_reset();
    check("rst_psw", PSW_OUT, 3'h0);
    wrap_up();
  end
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end
endmodule : testbench
bind exv_top exv_chk i_exv_chk (.*);
